// [cc_map.vh]
`ifndef CC_MAP_VH
`define CC_MAP_VH
// register byte offsets
`define CC_OFF_CTRL 8'h00
`define CC_OFF_TA_VAL 8'h04
`define CC_OFF_TA_RLD 8'h08
`define CC_OFF_TB_VAL 8'h0c
`define CC_OFF_TB_RLD 8'h10
`define CC_OFF_STAT 8'h14
`define CC_OFF_MASK 8'h18
`define CC_OFF_SINGLE 8'h1c
`define CC_OFF_DOUBLE 8'h20
// per-channel regions, index in paddr[5:2]
`define CC_REGION_MODE 2'h1
`define CC_REGION_VAL 2'h2
// control register fields
`define CTRL_TA_SEL 2:0
`define CTRL_TA_RUN 3
`define CTRL_TB_SEL 6:4
`define CTRL_TB_RUN 7
`define CTRL_STAGGER 8
`define CTRL_RST 9'h000
// clock select codes: 0..4 divide by 1,2,4,8,16
`define SEL_DIV_MAX 3'h4
`define SEL_UPSTREAM 3'h5
`define SEL_EXT 3'h6
// channel config fields
`define CFG_MODE 2:0
`define CFG_TSEL 3
`define CFG_RST 4'h0
// channel modes
`define MD_OFF 3'h0
`define MD_CAP_RISE 3'h1
`define MD_CAP_FALL 3'h2
`define MD_CAP_BOTH 3'h3
`define MD_CMP0 3'h4
`define MD_CMP1 3'h5
`define MD_CMP2 3'h6
`define MD_CMP3 3'h7
// status layout
`define ST_TA_OVF 16
`define ST_TB_OVF 17
`define ST_RST 18'h00000
// timer constants
`define TMR_MAX 16'hffff
`define TMR_RST 16'h0000
`define TMR_ONE 16'h0001
`define SLOT_LAST 3'h7
`endif

// [cc_channel.v]
`timescale 1ns/10ps
`default_nettype none
`include "cc_map.vh"
module cc_channel (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // configuration
   input wire [2:0] mode,
   input wire tsel,
   input wire allow,
   input wire slot_ok,
   // time bases
   input wire [15:0] ta,
   input wire [15:0] tb,
   input wire ovf_a,
   input wire ovf_b,
   // pin edges and software write
   input wire pin_rise,
   input wire pin_fall,
   input wire wr,
   input wire [15:0] wdata,
   // results
   output reg [15:0] value,
   output reg evt
);
   wire [15:0] tmr = tsel ? tb : ta;
   wire ovf = tsel ? ovf_b : ovf_a;
   wire is_cmp = mode[2];
   wire eq = is_cmp && (tmr == value);
   wire once = (mode == `MD_CMP2) || (mode == `MD_CMP3);
   // (R15) selected capture edge
   wire cap_hit = ((mode == `MD_CAP_RISE) && pin_rise) ||
      ((mode == `MD_CAP_FALL) && pin_fall) ||
      ((mode == `MD_CAP_BOTH) && (pin_rise || pin_fall));
   reg eq_q;
   reg pend;
   reg fired;
   wire cmp_hit = eq && !eq_q && allow && !(once && fired);
   wire trig = cap_hit || cmp_hit;
   // capture, compare match and staggered event release
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         value <= `TMR_RST;
         eq_q <= 1'b0;
         pend <= 1'b0;
         fired <= 1'b0;
         evt <= 1'b0;
      end else begin
         eq_q <= eq;
         // (R13) capture timer value
         if (wr)
            value <= wdata;
         else if (cap_hit)
            value <= tmr;
         // (R9) once per period
         if (cmp_hit && once)
            fired <= 1'b1;
         else if (ovf)
            fired <= 1'b0;
         // (R1) slot gated release
         evt <= slot_ok && (pend || trig);
         pend <= !slot_ok && (pend || trig);
      end
   end
endmodule // cc_channel
`default_nettype wire

// [capture_compare_array.v]
// Operation
// (R1) Up to 16 channels resolve to one clock, or to eight clocks when staggered.
// (R2) Two independent 16-bit timers each have their own reload register.
// (R3) Each timer clocks from a prescaled system clock or upstream timer overflows.
// (R4) The first timer can count edges of an external count input.
// (R5) Sixteen channel registers each pick a timer and capture or compare use.
// (R6) Each channel owns one pin, a capture input or a compare output.
// (R7) Compare mode 0 only interrupts, on every match, leaving the pin alone.
// (R8) Compare mode 1 inverts the pin on every match.
// (R9) Compare mode 2 interrupts at most once per timer period.
// (R10) Compare mode 3 sets the pin on match and clears it on timer overflow.
// (R11) Double register mode lets two channels toggle one shared pin.
// (R12) Single event option stops a channel after its first compare event.
// (R13) Capture copies the allocated timer into the channel register on a pin event.
// (R14) Every capture raises that channel's own interrupt status bit.
// (R15) The capture trigger is a rising, falling or either edge.
// (R16) Compare channels are checked against their timer continuously.
// (R17) On overflow a timer loads its reload value and keeps counting.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "cc_map.vh"
module capture_compare_array #(
   parameter CHANNELS = 16
) (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // timer clock sources
   input wire upstream_ovf,
   input wire ext_count_in,
   // channel pins
   input wire [15:0] pin_in,
   output reg [15:0] pin_out,
   output reg [15:0] pin_oe,
   // interrupt
   output reg irq
);
   reg [8:0] ctrl;
   reg [17:0] status;
   reg [17:0] mask;
   reg [15:0] single;
   reg [15:0] halted;
   reg [7:0] dbl;
   reg [3:0] ch_cfg [0:15];
   reg [3:0] psc;
   reg [2:0] slot;
   reg ext_prev;
   reg [15:0] pin_prev;
   reg [31:0] rd_data;
   reg rd_hit;
   // flattened timer and channel buses
   wire [31:0] tmr_flat;
   wire [31:0] rld_flat;
   wire [1:0] tmr_ovf;
   wire [255:0] val_flat;
   wire [15:0] evt;
   wire [31:0] evt_ext = {16'h0000, evt};
   wire [15:0] dbl_ext = {8'h00, dbl};
   // bus and mode decode
   wire stagger = ctrl[`CTRL_STAGGER];
   wire setup = psel && !penable;
   wire wr_go = psel && penable && pready && pwrite;
   wire rd_go = psel && penable && pready && !pwrite;
   wire [3:0] idx = paddr[5:2];
   wire mode_wr = wr_go && (paddr[7:6] == `CC_REGION_MODE);
   wire val_wr = wr_go && (paddr[7:6] == `CC_REGION_VAL);
   // input edges seen against the last cycle
   wire ext_rise = ext_count_in && !ext_prev;
   wire [15:0] pin_rise = pin_in & ~pin_prev;
   wire [15:0] pin_fall = ~pin_in & pin_prev;
   // prescaler taps for the divided clock selects
   wire [4:0] div_en = {&psc, &psc[2:0], &psc[1:0], psc[0], 1'b1};
   integer i;
   integer j;
   integer k;
   reg [2:0] ch_md;
   reg ch_ovf;
   reg [15:0] pin_en;
   reg [15:0] pin_tgl;
   reg [15:0] pin_set;
   reg [15:0] pin_clr;

   // selects the counting event for a timer
   function clk_tick;
      input [2:0] sel;
      input [4:0] div;
      input up;
      input ext;
      input first;
      begin
         if (sel <= `SEL_DIV_MAX)
            clk_tick = div[sel];
         else if (sel == `SEL_UPSTREAM)
            clk_tick = up;
         else if (sel == `SEL_EXT)
            clk_tick = ext && first;
         else
            clk_tick = 1'b0;
      end
   endfunction

   // next timer value, wrapping past the top to the reload value
   function [15:0] next_count;
      input [15:0] cur;
      input [15:0] rld;
      begin
         if (cur == `TMR_MAX)
            next_count = rld;
         else
            next_count = cur + `TMR_ONE;
      end
   endfunction

   // prescaler, stagger slot and input edge history
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         psc <= 4'h0;
         slot <= 3'h0;
         ext_prev <= 1'b0;
         pin_prev <= 16'h0000;
      end else begin
         psc <= psc + 4'h1;
         // (R1) rotating channel slot
         slot <= slot + 3'h1;
         ext_prev <= ext_count_in;
         pin_prev <= pin_in;
      end
   end

   // the two time bases
   // (R2) two independent timers
   genvar t;
   generate
      for (t = 0; t < 2; t = t + 1) begin : tb_gen
         reg [15:0] cnt;
         reg [15:0] rld;
         reg ovf_q;
         wire [2:0] sel = t ? ctrl[`CTRL_TB_SEL] : ctrl[`CTRL_TA_SEL];
         wire run = t ? ctrl[`CTRL_TB_RUN] : ctrl[`CTRL_TA_RUN];
         wire [7:0] val_off = t ? `CC_OFF_TB_VAL : `CC_OFF_TA_VAL;
         wire [7:0] rld_off = t ? `CC_OFF_TB_RLD : `CC_OFF_TA_RLD;
         // (R3) (R4) clock source select
         wire tick = run &&
            clk_tick(sel, div_en, upstream_ovf, ext_rise, t == 0) &&
            (!stagger || slot == `SLOT_LAST);
         assign tmr_flat[t*16 +: 16] = cnt;
         assign rld_flat[t*16 +: 16] = rld;
         assign tmr_ovf[t] = ovf_q;
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cnt <= `TMR_RST;
               rld <= `TMR_RST;
               ovf_q <= 1'b0;
            end else begin
               ovf_q <= 1'b0;
               if (wr_go && paddr == rld_off)
                  rld <= pwdata[15:0];
               if (wr_go && paddr == val_off)
                  cnt <= pwdata[15:0];
               else if (tick) begin
                  // (R17) reload on overflow
                  cnt <= next_count(cnt, rld);
                  ovf_q <= (cnt == `TMR_MAX);
               end
            end
         end
      end
   endgenerate

   // channel array
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g = g + 1) begin : ch_gen
         localparam integer SLOT_N = g % 8;
         wire [2:0] md = ch_cfg[g][`CFG_MODE];
         wire tsel = ch_cfg[g][`CFG_TSEL];
         // (R5) (R16) one dual purpose channel
         cc_channel u_ch (
            .pclk(pclk),
            .presetn(presetn),
            .mode(md),
            .tsel(tsel),
            .allow(!halted[g]),
            .slot_ok(!stagger || slot == SLOT_N[2:0]),
            .ta(tmr_flat[15:0]),
            .tb(tmr_flat[31:16]),
            .ovf_a(tmr_ovf[0]),
            .ovf_b(tmr_ovf[1]),
            .pin_rise(pin_rise[g]),
            .pin_fall(pin_fall[g]),
            .wr(val_wr && idx == g),
            .wdata(pwdata[15:0]),
            .value(val_flat[g*16 +: 16]),
            .evt(evt[g])
         );
      end
   endgenerate

   // compare modes that own their pin
   function drives_pin;
      input [2:0] md;
      begin
         drives_pin = (md == `MD_CMP1) || (md == `MD_CMP3);
      end
   endfunction

   // per channel pin requests, one process for the whole pin bus
   always @* begin
      ch_md = `MD_OFF;
      ch_ovf = 1'b0;
      pin_en = 16'h0000;
      pin_tgl = 16'h0000;
      pin_set = 16'h0000;
      pin_clr = 16'h0000;
      for (j = 0; j < 16; j = j + 1) begin
         ch_md = ch_cfg[j][`CFG_MODE];
         ch_ovf = tmr_ovf[ch_cfg[j][`CFG_TSEL]];
         // (R6) pin driven by compare modes 1 and 3, or by double register mode
         pin_en[j] = drives_pin(ch_md) || dbl_ext[j];
         // (R8) (R11) toggle on own or partner match
         pin_tgl[j] = ((ch_md == `MD_CMP1) && evt[j]) ||
            (dbl_ext[j] && evt_ext[j + 8]);
         // (R10) set on match, clear on overflow
         pin_set[j] = (ch_md == `MD_CMP3) && evt[j];
         pin_clr[j] = (ch_md == `MD_CMP3) && ch_ovf;
      end
   end

   // pin flops: a toggle beats a set, a set beats the overflow clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out <= 16'h0000;
         pin_oe <= 16'h0000;
      end else begin
         pin_oe <= pin_en;
         for (k = 0; k < 16; k = k + 1) begin
            if (pin_tgl[k])
               pin_out[k] <= !pin_out[k];
            else if (pin_set[k])
               pin_out[k] <= 1'b1;
            else if (pin_clr[k])
               pin_out[k] <= 1'b0;
         end
      end
   end

   // software configuration and single event bookkeeping
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `CTRL_RST;
         mask <= `ST_RST;
         single <= 16'h0000;
         halted <= 16'h0000;
         dbl <= 8'h00;
         for (i = 0; i < 16; i = i + 1)
            ch_cfg[i] <= `CFG_RST;
      end else begin
         if (wr_go && paddr == `CC_OFF_CTRL)
            ctrl <= pwdata[8:0];
         if (wr_go && paddr == `CC_OFF_MASK)
            mask <= pwdata[17:0];
         if (wr_go && paddr == `CC_OFF_SINGLE)
            single <= pwdata[15:0];
         if (wr_go && paddr == `CC_OFF_DOUBLE)
            dbl <= pwdata[7:0];
         for (i = 0; i < 16; i = i + 1) begin
            if (mode_wr && idx == i) begin
               ch_cfg[i] <= pwdata[3:0];
               halted[i] <= 1'b0;
            end
            // (R12) stop after first event
            if (evt[i] && single[i] && ch_cfg[i][2]) begin
               single[i] <= 1'b0;
               halted[i] <= 1'b1;
            end
         end
      end
   end

   // sticky status, cleared by reading, and the interrupt line
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= `ST_RST;
         irq <= 1'b0;
      end else begin
         // (R7) (R14) every event sets its bit
         if (rd_go && paddr == `CC_OFF_STAT)
            status <= (status & ~prdata[17:0]) | {tmr_ovf, evt};
         else
            status <= status | {tmr_ovf, evt};
         irq <= |(status & mask);
      end
   end

   // read data decode
   always @* begin
      rd_data = 32'h00000000;
      rd_hit = 1'b1;
      case (paddr[7:6])
         `CC_REGION_MODE: rd_data[3:0] = ch_cfg[idx];
         `CC_REGION_VAL: rd_data[15:0] = val_flat[idx*16 +: 16];
         default: begin
            case (paddr)
               `CC_OFF_CTRL: rd_data[8:0] = ctrl;
               `CC_OFF_TA_VAL: rd_data[15:0] = tmr_flat[15:0];
               `CC_OFF_TA_RLD: rd_data[15:0] = rld_flat[15:0];
               `CC_OFF_TB_VAL: rd_data[15:0] = tmr_flat[31:16];
               `CC_OFF_TB_RLD: rd_data[15:0] = rld_flat[31:16];
               `CC_OFF_STAT: rd_data[17:0] = status;
               `CC_OFF_MASK: rd_data[17:0] = mask;
               `CC_OFF_SINGLE: rd_data = {halted, single};
               `CC_OFF_DOUBLE: rd_data[7:0] = dbl;
               default: rd_hit = 1'b0;
            endcase
         end
      endcase
   end

   // apb answer: one wait-free access phase after setup
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         if (setup) begin
            prdata <= pwrite ? 32'h00000000 : rd_data;
            pslverr <= !rd_hit;
         end else if (!psel) begin
            pslverr <= 1'b0;
         end
      end
   end
endmodule // capture_compare_array
`default_nettype wire

// [cc_checker_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module cc_checker (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pins and interrupt
   input wire logic [15:0] pin_out,
   input wire logic [15:0] pin_oe,
   input wire logic irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // address classes
   wire bad = (paddr > 8'h20 && paddr < 8'h40) || paddr > 8'hbc;
   wire tmr = paddr > 8'h00 && paddr < 8'h14;
   property p_ans; psel && !penable |=> pready; endproperty
   a_ans: assert property (p_ans) else $error("no answer after setup");
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("ready too long");
   property p_acc; pready |-> psel && penable; endproperty
   a_acc: assert property (p_acc) else $error("ready outside access");
   property p_err; pready && bad |-> pslverr; endproperty
   a_err: assert property (p_err) else $error("unmapped not refused");
   property p_ok; pready && !bad |-> !pslverr; endproperty
   a_ok: assert property (p_ok) else $error("mapped refused");
   property p_zero; pready && pslverr && !pwrite |-> prdata == 32'h0;
   endproperty
   a_zero: assert property (p_zero) else $error("refused read not zero");
   property p_hi; pready && !pwrite && tmr |-> prdata[31:16] == 16'h0;
   endproperty
   a_hi: assert property (p_hi) else $error("timer upper bits set");
   property p_hold; pready |=> $stable(prdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_rst; $rose(presetn) |-> pin_out == 16'h0 && pin_oe == 16'h0
      && !irq && !pready; endproperty
   a_rst: assert property (p_rst) else $error("outputs busy at reset");
   property p_oe; $changed(pin_oe) |->
      $past(pready && pwrite) || $past(pready && pwrite, 2); endproperty
   a_oe: assert property (p_oe) else $error("pin enable moved alone");
endmodule // cc_checker
`default_nettype wire

// [pin_model.sv]
`timescale 1ns/10ps
`default_nettype none
module pin_model (
   // clock
   input wire logic pclk,
   // channel pins
   input wire logic [15:0] pin_out,
   input wire logic [15:0] pin_oe,
   output wire logic [15:0] pin_in,
   // timer sources
   output logic upstream_ovf = 1'b0,
   output logic ext_count_in = 1'b0
);
   logic [15:0] drv = 16'h0000;
   // wire level: the design wins where it drives
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv);
   // one pin level change, then settle
   task automatic set_pin(input int i, input logic v);
      @(posedge pclk);
      drv[i] <= v;
      repeat (6) @(posedge pclk);
   endtask
   task automatic up_pulses(input int n);
      repeat (n) begin
         @(posedge pclk);
         upstream_ovf <= 1'b1;
         @(posedge pclk);
         upstream_ovf <= 1'b0;
      end
      repeat (4) @(posedge pclk);
   endtask
   task automatic ext_edges(input int n);
      repeat (n) begin
         repeat (2) @(posedge pclk);
         ext_count_in <= 1'b1;
         repeat (2) @(posedge pclk);
         ext_count_in <= 1'b0;
      end
      repeat (4) @(posedge pclk);
   endtask
endmodule // pin_model
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, rd;
   logic [15:0] po = 16'h0;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, upstream_ovf, ext_count_in, irq;
   wire logic [15:0] pin_in, pin_out, pin_oe;
   int err_total = 0, n_compared = 0, t0 = 0, r1 = 0, a, b;
   int md [4] = '{5, 7, 4, 6};
   capture_compare_array dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .upstream_ovf(upstream_ovf), .ext_count_in(ext_count_in),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
   pin_model pm (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_in(pin_in), .upstream_ovf(upstream_ovf),
      .ext_count_in(ext_count_in));
   // clock
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // count edges on compare pins
   always @(posedge pclk) begin
      po <= pin_out;
      t0 <= t0 + (pin_out[0] != po[0]);
      r1 <= r1 + (pin_out[1] && !po[1]);
   end
   // one apb transfer, waiting for ready
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) begin
         err_total++;
         $display("MISMATCH %0t no ready from the slave", $time);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      apb(1'b1, ad, d);
   endtask
   task automatic rdchk(input logic [7:0] ad, input logic [31:0] e);
      apb(1'b0, ad, 32'h0);
      chk(rd, e);
   endtask
   task automatic t_regs;
      rdchk(8'h00, 32'h0);
      wr(8'h08, 32'h1234abcd);
      rdchk(8'h08, 32'h0000abcd);
      rdchk(8'h30, 32'h0);
      chk({31'h0, er}, 32'h1);
      $display("test regs done");
   endtask
   task automatic t_count;
      wr(8'h0c, 32'h10);
      wr(8'h00, 32'hd0);
      pm.up_pulses(3);
      rdchk(8'h0c, 32'h13);
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h0e);
      pm.ext_edges(4);
      rdchk(8'h04, 32'h4);
      wr(8'h08, 32'h100);
      wr(8'h04, 32'hfffe);
      pm.ext_edges(3);
      wr(8'h00, 32'h0);
      rdchk(8'h04, 32'h101);
      rdchk(8'h14, 32'h10000);
      rdchk(8'h14, 32'h0);
      $display("test timers done");
   endtask
   task automatic t_rate;
      int cw [3] = '{32'h1c0, 32'h180, 32'ha0};
      int ex [3] = '{5, 10, 20};
      for (int n = 0; n < 3; n++) begin
         wr(8'h0c, 32'h0);
         wr(8'h00, cw[n]);
         repeat (78) @(posedge pclk);
         wr(8'h00, 32'h0);
         rdchk(8'h0c, ex[n]);
      end
      $display("test rates done");
   endtask
   task automatic t_cap;
      wr(8'h18, 32'h10);
      for (int m = 1; m <= 3; m++) begin
         wr(8'h50, m + 8);
         wr(8'h0c, 32'h100 + m);
         pm.set_pin(4, 1'b1);
         wr(8'h0c, 32'h200 + m);
         pm.set_pin(4, 1'b0);
         chk({31'h0, irq}, 32'h1);
         rdchk(8'h90, m == 1 ? 32'h100 + m : 32'h200 + m);
         rdchk(8'h14, 32'h10);
         repeat (2) @(posedge pclk);
         chk({31'h0, irq}, 32'h0);
      end
      wr(8'h18, 32'h0);
      pm.set_pin(4, 1'b1);
      chk({31'h0, irq}, 32'h0);
      rdchk(8'h14, 32'h10);
      $display("test capture done");
   endtask
   task automatic t_cmp;
      wr(8'h08, 32'hff00);
      wr(8'h04, 32'hff00);
      for (int i = 0; i < 4; i++) begin
         wr(8'h40 + 4 * i, md[i]);
         wr(8'h80 + 4 * i, 32'hff40 + 32'h20 * i);
      end
      wr(8'h00, 32'h08);
      apb(1'b0, 8'h14, 32'h0);
      a = t0;
      b = r1;
      repeat (1024) @(posedge pclk);
      chk(t0 - a, 32'h4);
      chk(r1 - b, 32'h4);
      chk({28'h0, pin_oe[3:0]}, 32'h3);
      rdchk(8'h14, 32'h1000f);
      wr(8'h60, 32'h5);
      wr(8'ha0, 32'hffd0);
      wr(8'h20, 32'h1);
      wr(8'h1c, 32'h2);
      a = t0;
      b = r1;
      repeat (1024) @(posedge pclk);
      chk(t0 - a, 32'h8);
      chk(r1 - b, 32'h1);
      rdchk(8'h1c, 32'h20000);
      $display("test compare done");
   endtask
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // watchdog
   initial begin
      #400000;
      err_total++;
      final_report;
   end
   // reset and test sequence
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_count;
      t_rate;
      t_cap;
      t_cmp;
      final_report;
   end
endmodule // tb_top
bind capture_compare_array cc_checker chk_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_out(pin_out),
   .pin_oe(pin_oe), .irq(irq));
`default_nettype wire
